//--- pkg/iolofc_pkg.sv
// Purpose: constants for the 32-line output, filter and change irq block
// Assumes: Avalon-MM byte addressing of a 32-bit register file
// Notes: byte offsets; register index is offset divided by four
package iolofc_pkg;
   localparam int unsigned NUM_LINES = 32;
   localparam int unsigned ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_OUT_EN = 8'h10;
   localparam logic [7:0] OFF_OUT_DIS = 8'h14;
   localparam logic [7:0] OFF_OUT_STATE = 8'h18;
   localparam logic [7:0] OFF_FILT_EN = 8'h20;
   localparam logic [7:0] OFF_FILT_DIS = 8'h24;
   localparam logic [7:0] OFF_FILT_STATE = 8'h28;
   localparam logic [7:0] OFF_DRV_SET = 8'h30;
   localparam logic [7:0] OFF_DRV_CLR = 8'h34;
   localparam logic [7:0] OFF_DRV_STATE = 8'h38;
   localparam logic [7:0] OFF_PIN_LEVEL = 8'h3c;
   localparam logic [7:0] OFF_IRQ_EN = 8'h40;
   localparam logic [7:0] OFF_IRQ_DIS = 8'h44;
   localparam logic [7:0] OFF_IRQ_ENABLED = 8'h48;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h4c;
   localparam logic [7:0] OFF_DWP_EN = 8'ha0;
   localparam logic [7:0] OFF_DWP_DIS = 8'ha4;
   localparam logic [7:0] OFF_DWP_STATE = 8'ha8;
   // Reset and unmapped read values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   // Glitch filter length in clock cycles
   localparam int unsigned FILT_CYCLES = 2;
   localparam logic [1:0] FILT_MAX = 2'h1;
   // Bus answer states
   typedef enum logic [1:0] {
      IOLOFC_IDLE = 2'b01,
      IOLOFC_ACK = 2'b10
   } iolofc_bus_type;
endpackage

//--- src/iolofc_top.sv
// Purpose: per-line output driver, drive value, glitch filter and input
//    change interrupt control for 32 I/O lines
// Assumes: single 100 MHz clock, Avalon-MM slave with waitrequest
// Notes: pins are sampled by two flip-flops before any logic
//    writes act at the edge that completes the access
//    change status bits are cleared by writing ones to them
//    the readback holds its last sample while the clock is stopped
`timescale 1ns/1ps
module iolofc_top
   import iolofc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [NUM_LINES-1:0] pin_in,
   output logic [NUM_LINES-1:0] pin_out,
   output logic [NUM_LINES-1:0] pin_oe_n,
   output logic irq
);

   // Bus handshake state
   iolofc_bus_type state;
   iolofc_bus_type next_state;
   // Per-line control state
   logic [31:0] output_enabled;
   logic [31:0] next_output_enabled;
   logic [31:0] filter_on;
   logic [31:0] next_filter_on;
   logic [31:0] drive_value;
   logic [31:0] next_drive_value;
   logic [31:0] irq_enabled;
   logic [31:0] next_irq_enabled;
   logic [31:0] write_permit;
   logic [31:0] next_write_permit;
   logic [31:0] irq_status;
   logic [31:0] next_irq_status;
   logic [31:0] next_readdata;
   // Pin sampling, filter and change detection
   logic [31:0] sync1;
   logic [31:0] sync2;
   logic [31:0] level;
   logic [31:0] next_level;
   logic [31:0] level_prev;
   logic [1:0] filt_cnt [NUM_LINES];
   logic [1:0] next_filt_cnt [NUM_LINES];
   // Bus decode helpers
   logic [31:0] wmask;
   logic wr_go;
   logic rd_go;
   logic [31:0] wd;
   logic [31:0] changed;
   logic [31:0] status_clear;

   // Byte lanes expand to a bit mask
   assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wd = writedata & wmask;
   // A write lands at the edge where waitrequest is seen low
   assign wr_go = write && (state == IOLOFC_ACK);
   assign rd_go = read && !write && (state == IOLOFC_IDLE);
   assign waitrequest = (read || write) && (state == IOLOFC_IDLE);

   // Bus answer sequencer: one wait cycle, then the request completes
   // The wait cycle lets read data be registered before it is taken
   always_comb begin
      next_state = state;
      case (state)
         IOLOFC_IDLE: begin
            if (read || write) begin
               next_state = IOLOFC_ACK;
            end
         end
         IOLOFC_ACK: begin
            next_state = IOLOFC_IDLE;
         end
         default: begin
            next_state = IOLOFC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= IOLOFC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Output driver pair: enable and disable act on one bit per line
   // Zero bits in either written word leave the line as it was
   always_comb begin
      next_output_enabled = output_enabled;
      if (wr_go) begin
         case (address)
            OFF_OUT_EN: begin
               next_output_enabled = output_enabled | wd;
            end
            OFF_OUT_DIS: begin
               next_output_enabled = output_enabled & ~wd;
            end
            default: begin
               next_output_enabled = output_enabled;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         output_enabled <= RST_ZERO;
      end else begin
         output_enabled <= next_output_enabled;
      end
   end

   // Glitch filter pair: switches the input filter of each line
   // The filter itself runs in the per-line loop below
   always_comb begin
      next_filter_on = filter_on;
      if (wr_go) begin
         case (address)
            OFF_FILT_EN: begin
               next_filter_on = filter_on | wd;
            end
            OFF_FILT_DIS: begin
               next_filter_on = filter_on & ~wd;
            end
            default: begin
               next_filter_on = filter_on;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         filter_on <= RST_ZERO;
      end else begin
         filter_on <= next_filter_on;
      end
   end

   // Drive value: set and clear words, or a direct write of the state
   // A direct write only reaches lines whose permit bit is set
   always_comb begin
      next_drive_value = drive_value;
      if (wr_go) begin
         case (address)
            OFF_DRV_SET: begin
               next_drive_value = drive_value | wd;
            end
            OFF_DRV_CLR: begin
               next_drive_value = drive_value & ~wd;
            end
            OFF_DRV_STATE: begin
               // Only permitted lines within written lanes take the value
               next_drive_value = (drive_value & ~(write_permit & wmask))
                  | (writedata & write_permit & wmask);
            end
            default: begin
               next_drive_value = drive_value;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drive_value <= RST_ZERO;
      end else begin
         drive_value <= next_drive_value;
      end
   end

   // Change interrupt pair: masks each line's change flag
   // Flags still set while masked, so enabling later raises irq
   always_comb begin
      next_irq_enabled = irq_enabled;
      if (wr_go) begin
         case (address)
            OFF_IRQ_EN: begin
               next_irq_enabled = irq_enabled | wd;
            end
            OFF_IRQ_DIS: begin
               next_irq_enabled = irq_enabled & ~wd;
            end
            default: begin
               next_irq_enabled = irq_enabled;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_enabled <= RST_ZERO;
      end else begin
         irq_enabled <= next_irq_enabled;
      end
   end

   // Direct write permit pair: chooses the writable drive lines
   // All lines start read-only so a stray write cannot move a pin
   always_comb begin
      next_write_permit = write_permit;
      if (wr_go) begin
         case (address)
            OFF_DWP_EN: begin
               next_write_permit = write_permit | wd;
            end
            OFF_DWP_DIS: begin
               next_write_permit = write_permit & ~wd;
            end
            default: begin
               next_write_permit = write_permit;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_permit <= RST_ZERO;
      end else begin
         write_permit <= next_write_permit;
      end
   end

   // Pin synchroniser; only the second stage feeds logic
   // The first stage may go metastable, so nothing else reads it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= RST_ZERO;
         sync2 <= RST_ZERO;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   // Per-line glitch filter: a level must hold for FILT_CYCLES cycles
   // A one-cycle glitch never reaches the readback or the change flags
   generate
      for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
         always_comb begin
            next_filt_cnt[i] = filt_cnt[i];
            next_level[i] = level[i];
            if (!filter_on[i]) begin
               next_level[i] = sync2[i];
               next_filt_cnt[i] = 2'h0;
            end else if (sync2[i] == level[i]) begin
               next_filt_cnt[i] = 2'h0;
            end else if (filt_cnt[i] >= FILT_MAX) begin
               next_level[i] = sync2[i];
               next_filt_cnt[i] = 2'h0;
            end else begin
               next_filt_cnt[i] = filt_cnt[i] + 2'h1;
            end
         end

         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               filt_cnt[i] <= 2'h0;
            end else begin
               filt_cnt[i] <= next_filt_cnt[i];
            end
         end
      end
   endgenerate

   // Readback register samples only on clock edges, holds when stopped
   // The delayed copy feeds the change detector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         level <= RST_ZERO;
         level_prev <= RST_ZERO;
      end else begin
         level <= next_level;
         level_prev <= level;
      end
   end

   // Change detection: sticky flags, a change wins over a same-cycle clear
   // Software clears a flag by writing a one to it
   assign changed = level ^ level_prev;
   assign status_clear = (wr_go && (address == OFF_IRQ_STATUS)) ? wd
      : RST_ZERO;

   always_comb begin
      next_irq_status = (irq_status & ~status_clear) | changed;
   end

   // Interrupt output follows the unmasked flags cycle for cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_status <= RST_ZERO;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & next_irq_enabled);
      end
   end

   // Read data mux, registered on the accepting cycle
   // The value then stands unchanged at the completing edge
   always_comb begin
      next_readdata = readdata;
      if (rd_go) begin
         case (address)
            OFF_OUT_STATE: begin
               next_readdata = output_enabled;
            end
            OFF_FILT_STATE: begin
               next_readdata = filter_on;
            end
            OFF_DRV_STATE: begin
               next_readdata = drive_value;
            end
            OFF_PIN_LEVEL: begin
               next_readdata = level;
            end
            OFF_IRQ_ENABLED: begin
               next_readdata = irq_enabled;
            end
            OFF_IRQ_STATUS: begin
               next_readdata = irq_status;
            end
            OFF_DWP_STATE: begin
               next_readdata = write_permit;
            end
            default: begin
               next_readdata = UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata <= RST_ZERO;
      end else begin
         readdata <= next_readdata;
      end
   end

   // Pin drive
   // A set enable bit pulls the active-low enable of its line low
   assign pin_out = drive_value;
   assign pin_oe_n = ~output_enabled;

endmodule // iolofc_top

//--- verification/iolofc_pins.sv
// Purpose: model of the 32 external lines
// Assumes: an outside source sets undriven lines
// Notes: a driven line shows the block's drive value
`timescale 1ns/1ps
module iolofc_pins
   import iolofc_pkg::*;
(
   input wire logic [NUM_LINES-1:0] pin_out,
   input wire logic [NUM_LINES-1:0] pin_oe_n,
   input wire logic [NUM_LINES-1:0] ext_level,
   output logic [NUM_LINES-1:0] pin_in
);
   // Line level from block driver or outside source
   assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // iolofc_pins

//--- verification/iolofc_sva.sv
// Purpose: port assertions for the line control block
// Assumes: a write acts at its ack edge
// Notes: write antecedents use full byte lanes only
`timescale 1ns/1ps
module iolofc_sva
   import iolofc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [NUM_LINES-1:0] pin_in,
   input wire logic [NUM_LINES-1:0] pin_out,
   input wire logic [NUM_LINES-1:0] pin_oe_n,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Completed bus accesses
   sequence s_wr(logic [7:0] a);
      write && !waitrequest && address == a && byteenable == 4'hf;
   endsequence
   sequence s_rd(logic [7:0] a);
      read && !waitrequest && address == a;
   endsequence
   AST_OE_ON: assert property (s_wr(OFF_OUT_EN) |=>
      (pin_oe_n & $past(writedata)) == 32'h0) else $error("oe on");
   AST_OE_KEEP: assert property (s_wr(OFF_OUT_EN) |=>
      ((pin_oe_n ^ $past(pin_oe_n)) & ~$past(writedata)) == 32'h0)
      else $error("oe zero bit");
   AST_OE_OFF: assert property (s_wr(OFF_OUT_DIS) |=>
      (~pin_oe_n & $past(writedata)) == 32'h0) else $error("oe off");
   AST_SET: assert property (s_wr(OFF_DRV_SET) |=>
      (~pin_out & $past(writedata)) == 32'h0) else $error("set");
   AST_CLR: assert property (s_wr(OFF_DRV_CLR) |=>
      (pin_out & $past(writedata)) == 32'h0) else $error("clear");
   AST_OSTATE: assert property (s_rd(OFF_OUT_STATE) |->
      readdata == ~pin_oe_n) else $error("out state");
   AST_DSTATE: assert property (s_rd(OFF_DRV_STATE) |->
      readdata == pin_out) else $error("drive state");
   AST_IRQ_OFF: assert property (s_wr(OFF_IRQ_DIS) ##0
      (&writedata) |-> ##2 !irq) else $error("irq off");
endmodule // iolofc_sva
bind iolofc_top iolofc_sva i_sva (.clk(clk), .resetn(resetn),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe_n(pin_oe_n), .irq(irq));

//--- verification/test_io_line_output_filter_irq_ctl.sv
// Purpose: self-checking bench for the line control block
// Assumes: each access waits for waitrequest low, no fixed latency
// Notes: byte lanes always full
`timescale 1ns/1ps
module test_io_line_output_filter_irq_ctl import iolofc_pkg::*;;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata, pin_in, pin_out, pin_oe_n;
   logic [31:0] ext_level = 32'h0;
   logic waitrequest, irq;
   int errors = 0;
   int checks = 0;
   always #5 clk = ~clk;
   iolofc_top i_dut (.clk(clk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .irq(irq));
   iolofc_pins i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_level(ext_level), .pin_in(pin_in));
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: exp %h got %h", $time, e, g);
      end
   endtask
   // One Avalon access, held until waitrequest is low
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do begin
         @(posedge clk);
      end while (waitrequest);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(e, q);
   endtask
   task automatic t_reset();
      chk(32'hffff_ffff, pin_oe_n);
      rc(OFF_OUT_STATE, RST_ZERO);
      rc(OFF_FILT_STATE, RST_ZERO);
      rc(OFF_DRV_STATE, RST_ZERO);
      rc(8'h1c, UNMAPPED_READ);
   endtask
   task automatic t_out();
      wr(OFF_OUT_EN, 32'ha5a5_0ff0);
      wr(OFF_OUT_EN, 32'h0);
      wr(OFF_OUT_DIS, 32'h0000_00f0);
      wr(OFF_OUT_STATE, 32'hffff_ffff);
      rc(OFF_OUT_STATE, 32'ha5a5_0f00);
      chk(32'h5a5a_f0ff, pin_oe_n);
   endtask
   task automatic t_filt();
      wr(OFF_FILT_EN, 32'hffff_0001);
      wr(OFF_FILT_DIS, 32'h0f0f_0000);
      rc(OFF_FILT_STATE, 32'hf0f0_0001);
   endtask
   task automatic t_drv();
      wr(OFF_DRV_SET, 32'hf0f0_f0f0);
      wr(OFF_DRV_CLR, 32'h3030_3030);
      rc(OFF_DRV_STATE, 32'hc0c0_c0c0);
      wr(OFF_DRV_STATE, 32'h0000_ffff);
      rc(OFF_DRV_STATE, 32'hc0c0_c0c0);
      wr(OFF_DWP_EN, 32'h0000_00ff);
      wr(OFF_DRV_STATE, 32'h0000_000f);
      rc(OFF_DRV_STATE, 32'hc0c0_c00f);
      wr(OFF_DWP_DIS, 32'h0000_000f);
      rc(OFF_DWP_STATE, 32'h0000_00f0);
      wr(OFF_DRV_STATE, 32'hffff_fff0);
      rc(OFF_DRV_STATE, 32'hc0c0_c0ff);
      chk(32'hc0c0_c0ff, pin_out);
   endtask
   task automatic t_pin();
      @(posedge clk);
      ext_level <= 32'h1234_5678;
      repeat (10) @(posedge clk);
      rc(OFF_PIN_LEVEL, 32'h9290_5078);
   endtask
   task automatic t_irq();
      wr(OFF_IRQ_EN, 32'h0000_0001);
      rc(OFF_IRQ_ENABLED, 32'h0000_0001);
      wr(OFF_IRQ_STATUS, 32'hffff_ffff);
      rc(OFF_IRQ_STATUS, RST_ZERO);
      @(posedge clk);
      ext_level <= 32'h1234_5679;
      repeat (10) @(posedge clk);
      chk(32'h1, {31'h0, irq});
      wr(OFF_IRQ_DIS, 32'hffff_ffff);
      repeat (2) @(posedge clk);
      chk(32'h0, {31'h0, irq});
      wr(OFF_IRQ_EN, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'h1, {31'h0, irq});
      rc(OFF_IRQ_STATUS, 32'h0000_0001);
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      // Single-cycle glitch on a filtered line is dropped
      ext_level <= 32'h1234_5678;
      @(posedge clk);
      ext_level <= 32'h1234_5679;
      repeat (10) @(posedge clk);
      chk(32'h0, {31'h0, irq});
      rc(OFF_IRQ_STATUS, RST_ZERO);
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Main sequence after an 8-cycle reset
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      t_reset();
      t_out();
      t_filt();
      t_drv();
      t_pin();
      t_irq();
      print_verdict();
   end
   // Watchdog well past the expected run length
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
endmodule // test_io_line_output_filter_irq_ctl
